// [imc_consts.svh]
// constant values of the input mapping and mode control block
`ifndef IMC_CONSTS_SVH
`define IMC_CONSTS_SVH

`define IMC_NCH 8
`define IMC_AW 3
`define IMC_DW 8
`define IMC_SYNC_STAGES 2

`define IMC_OFF_OUT_CTRL 3'h0
`define IMC_OFF_MAP_A 3'h1
`define IMC_OFF_MAP_B 3'h2
`define IMC_OFF_PWM_A_MAP 3'h3
`define IMC_OFF_PWM_B_MAP 3'h4
`define IMC_OFF_IN_MON 3'h5
`define IMC_OFF_MODE 3'h6

`define IMC_RST_OUT_CTRL 8'h00
`define IMC_RST_MAP_A 8'h04
`define IMC_RST_MAP_B 8'h08
`define IMC_RST_PWM_MAP 8'h00

`endif

// [imc_ctrl.sv]
// input mapping, operating mode and supply gating of the channel switch
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "imc_consts.svh"

// Behaviour
// (R1) reset maps input a to channel 2, input b to channel 3
// (R2) software programs a channel map register for each input pin
// (R3) channel drive is OR of output bit, mapped pwm, mapped inputs
// (R4) input levels readable in monitor register, also in fallback
// (R5) select low and an input high gives fallback with default channels
// (R6) select low and all inputs low gives sleep
// (R7) host holds select pin at new level for the minimum time
// (R8) select low returns all serial registers to defaults
// (R9) select low and inputs low disables undervoltage detectors
// (R10) select low, inputs low: serial refused, data output high impedance
// (R11) both supplies under threshold: no channels, no serial, registers reset
// (R12) digital supply undervoltage blocks serial and resets registers
// (R13) analog undervoltage disables channels, re-enabled at operating level
// (R14) between thresholds channels on stay on, new switch-on refused
// (R15) switch-on request outside active moves to active or fallback
// (R16) input pins and select pin synchronised before use
module imc_ctrl
  import imc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_parallel_input_a,
  input wire logic i_parallel_input_b,
  input wire logic i_lowpower_sel,
  input wire logic i_chip_select_low_n,
  input wire logic [1:0] i_pwm,
  input wire imc_supply_t i_supply,
  input wire imc_bus_req_t i_bus,
  output logic [`IMC_DW-1:0] o_rdata,
  output logic [`IMC_NCH-1:0] o_chan_drive,
  output imc_mode_t o_mode,
  output logic o_serial_en,
  output logic o_so_oe_n,
  output logic o_uv_det_en
);

  logic [2:0] pins_s;
  logic in_a_s;
  logic in_b_s;
  logic lp_s;

  // (R16) pin synchronisers
  imc_sync #(.W(3)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_lowpower_sel, i_parallel_input_b, i_parallel_input_a}),
    .o_sync(pins_s)
  );

  assign in_a_s = pins_s[0];
  assign in_b_s = pins_s[1];
  assign lp_s = pins_s[2];

  // register file
  logic [`IMC_DW-1:0] out_ctrl_q, out_ctrl_d;
  logic [`IMC_DW-1:0] input_a_channel_map_q, input_a_channel_map_d;
  logic [`IMC_DW-1:0] input_b_channel_map_q, input_b_channel_map_d;
  logic [`IMC_DW-1:0] pwm_a_map_q, pwm_a_map_d;
  logic [`IMC_DW-1:0] pwm_b_map_q, pwm_b_map_d;
  logic [`IMC_DW-1:0] rdata_q, rdata_d;
  logic [1:0] input_level_monitor;
  logic serial_ok;
  logic reg_clr;
  logic quiet;

  // (R9) both inputs low with select low: the quiet sleep condition
  assign quiet = !lp_s && !in_a_s && !in_b_s;
  // (R10) (R12) serial refused in quiet sleep or digital undervoltage
  assign serial_ok = !quiet && !i_supply.vdd_uv;
  // (R8) (R11) (R12) defaults on select low or digital undervoltage
  assign reg_clr = !lp_s || i_supply.vdd_uv;
  // (R4) live levels, independent of mode
  assign input_level_monitor = {in_b_s, in_a_s};

  always_comb begin
    out_ctrl_d = out_ctrl_q;
    input_a_channel_map_d = input_a_channel_map_q;
    input_b_channel_map_d = input_b_channel_map_q;
    pwm_a_map_d = pwm_a_map_q;
    pwm_b_map_d = pwm_b_map_q;
    rdata_d = 8'h00;
    if (reg_clr) begin
      // (R8) registers back to defaults
      out_ctrl_d = `IMC_RST_OUT_CTRL;
      input_a_channel_map_d = `IMC_RST_MAP_A;
      input_b_channel_map_d = `IMC_RST_MAP_B;
      pwm_a_map_d = `IMC_RST_PWM_MAP;
      pwm_b_map_d = `IMC_RST_PWM_MAP;
    end else if (i_bus.wr && serial_ok) begin
      // (R2) map registers are software writable
      case (i_bus.addr)
        `IMC_OFF_OUT_CTRL: out_ctrl_d = i_bus.wdata;
        `IMC_OFF_MAP_A: input_a_channel_map_d = i_bus.wdata;
        `IMC_OFF_MAP_B: input_b_channel_map_d = i_bus.wdata;
        `IMC_OFF_PWM_A_MAP: pwm_a_map_d = i_bus.wdata;
        `IMC_OFF_PWM_B_MAP: pwm_b_map_d = i_bus.wdata;
        default: out_ctrl_d = out_ctrl_q;
      endcase
    end
    // a blocked read answers zero
    if (i_bus.rd && serial_ok) begin
      case (i_bus.addr)
        `IMC_OFF_OUT_CTRL: rdata_d = out_ctrl_q;
        `IMC_OFF_MAP_A: rdata_d = input_a_channel_map_q;
        `IMC_OFF_MAP_B: rdata_d = input_b_channel_map_q;
        `IMC_OFF_PWM_A_MAP: rdata_d = pwm_a_map_q;
        `IMC_OFF_PWM_B_MAP: rdata_d = pwm_b_map_q;
        // (R4) input monitor read
        `IMC_OFF_IN_MON: rdata_d = {6'h00, input_level_monitor};
        `IMC_OFF_MODE: rdata_d = {6'h00, o_mode};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      // (R1) default input mapping
      out_ctrl_q <= `IMC_RST_OUT_CTRL;
      input_a_channel_map_q <= `IMC_RST_MAP_A;
      input_b_channel_map_q <= `IMC_RST_MAP_B;
      pwm_a_map_q <= `IMC_RST_PWM_MAP;
      pwm_b_map_q <= `IMC_RST_PWM_MAP;
      rdata_q <= 8'h00;
    end else begin
      out_ctrl_q <= out_ctrl_d;
      input_a_channel_map_q <= input_a_channel_map_d;
      input_b_channel_map_q <= input_b_channel_map_d;
      pwm_a_map_q <= pwm_a_map_d;
      pwm_b_map_q <= pwm_b_map_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  // channel request, mode and supply gating
  logic [`IMC_NCH-1:0] req;
  logic [`IMC_NCH-1:0] chan_q, chan_d;
  imc_mode_t mode_q, mode_d;
  logic serial_en_q, so_oe_n_q, uv_det_en_q;
  logic serial_en_d, so_oe_n_d, uv_det_en_d;

  always_comb begin
    // (R3) or of output bits, mapped pwm and mapped inputs
    req = out_ctrl_q
        | (i_pwm[0] ? pwm_a_map_q : 8'h00)
        | (i_pwm[1] ? pwm_b_map_q : 8'h00)
        | (in_a_s ? input_a_channel_map_q : 8'h00)
        | (in_b_s ? input_b_channel_map_q : 8'h00);
    if (!lp_s) begin
      // (R5) fallback drives only the default channels
      req = (in_a_s ? `IMC_RST_MAP_A : 8'h00)
          | (in_b_s ? `IMC_RST_MAP_B : 8'h00);
    end
    // (R5) (R6) (R15) mode from select pin, inputs and requests
    if (!lp_s) begin
      mode_d = (in_a_s || in_b_s) ? IMC_FALLBACK : IMC_SLEEP;
    end else begin
      mode_d = (req != 8'h00) ? IMC_ACTIVE : IMC_IDLE;
    end
    // (R11) (R13) analog undervoltage forces every channel off
    if (i_supply.vs_uv) begin
      chan_d = 8'h00;
    end else if (!i_supply.vs_op) begin
      // (R14) hold what is on, refuse new switch-on
      chan_d = req & chan_q;
    end else begin
      chan_d = req;
    end
    serial_en_d = serial_ok;
    // (R10) data output stays high impedance while serial is refused
    so_oe_n_d = i_chip_select_low_n || !serial_ok;
    // (R9) detectors off in quiet sleep
    uv_det_en_d = !quiet;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      chan_q <= 8'h00;
      mode_q <= IMC_SLEEP;
      serial_en_q <= 1'b0;
      so_oe_n_q <= 1'b1;
      uv_det_en_q <= 1'b0;
    end else begin
      chan_q <= chan_d;
      mode_q <= mode_d;
      serial_en_q <= serial_en_d;
      so_oe_n_q <= so_oe_n_d;
      uv_det_en_q <= uv_det_en_d;
    end
  end

  assign o_chan_drive = chan_q;
  assign o_mode = mode_q;
  assign o_serial_en = serial_en_q;
  assign o_so_oe_n = so_oe_n_q;
  assign o_uv_det_en = uv_det_en_q;

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_quiet_pins;
    !i_lowpower_sel && !i_parallel_input_a && !i_parallel_input_b;
  endsequence

  sequence s_fallback_pins;
    !i_lowpower_sel && i_parallel_input_a;
  endsequence

  a_reset_map_default: assert property ( // (R1)
    $rose(i_rst_n) |-> input_a_channel_map_q == 8'h04
      && input_b_channel_map_q == 8'h08)
    else $error("default input map wrong after reset");

  a_map_write_takes: assert property ( // (R2)
    i_bus.wr && serial_ok && !reg_clr && i_bus.addr == 3'h1
      |=> input_a_channel_map_q == $past(i_bus.wdata))
    else $error("input a map write lost");

  a_drive_or_terms: assert property ( // (R3)
    lp_s && i_supply.vs_op && !i_supply.vs_uv && in_a_s
      |=> (o_chan_drive & $past(input_a_channel_map_q))
        == $past(input_a_channel_map_q))
    else $error("mapped input a not driving its channels");

  a_monitor_read_val: assert property ( // (R4)
    i_bus.rd && serial_ok && i_bus.addr == 3'h5
      |=> o_rdata == {6'h00, $past(in_b_s), $past(in_a_s)})
    else $error("input monitor read wrong");

  a_fallback_entry: assert property ( // (R5)
    s_fallback_pins ##1 s_fallback_pins ##1 s_fallback_pins
      |=> o_mode == IMC_FALLBACK)
    else $error("fallback not entered");

  a_sleep_entry: assert property ( // (R6)
    s_quiet_pins ##1 s_quiet_pins ##1 s_quiet_pins
      |=> o_mode == IMC_SLEEP && o_chan_drive == 8'h00)
    else $error("sleep not entered");

  a_select_low_clear: assert property ( // (R8)
    !lp_s |=> out_ctrl_q == 8'h00 && pwm_a_map_q == 8'h00)
    else $error("registers not cleared on select low");

  a_quiet_uv_serial: assert property ( // (R9) (R10)
    quiet |=> !o_uv_det_en && !o_serial_en && o_so_oe_n)
    else $error("quiet sleep left detectors or serial on");

  a_vdd_uv_block: assert property ( // (R12)
    i_supply.vdd_uv && i_bus.rd |=> o_rdata == 8'h00 && !o_serial_en)
    else $error("serial not blocked on digital undervoltage");

  a_vs_uv_off: assert property ( // (R11) (R13)
    i_supply.vs_uv |=> o_chan_drive == 8'h00)
    else $error("channels on during analog undervoltage");

  a_no_new_on: assert property ( // (R14)
    !i_supply.vs_uv && !i_supply.vs_op
      |=> (o_chan_drive & ~$past(o_chan_drive)) == 8'h00)
    else $error("channel switched on between thresholds");

  a_active_on_req: assert property ( // (R15)
    lp_s && out_ctrl_q != 8'h00 |=> o_mode == IMC_ACTIVE)
    else $error("request did not give active mode");

  a_out_bit_drive: assert property ( // (R3)
    lp_s && i_supply.vs_op && !i_supply.vs_uv
      |=> (o_chan_drive & $past(out_ctrl_q)) == $past(out_ctrl_q))
    else $error("output control bit not driving its channel");

  a_pwm_map_drive: assert property ( // (R3)
    lp_s && i_supply.vs_op && !i_supply.vs_uv && i_pwm[0]
      |=> (o_chan_drive & $past(pwm_a_map_q)) == $past(pwm_a_map_q))
    else $error("pwm a not driving its mapped channels");

  a_fallback_defaults: assert property ( // (R5)
    !lp_s && i_supply.vs_op && !i_supply.vs_uv
      |=> o_chan_drive == {4'h0, $past(in_b_s), $past(in_a_s), 2'h0})
    else $error("fallback drive not the default channels");

  a_fallback_mode: assert property ( // (R5)
    !lp_s && (in_a_s || in_b_s) |=> o_mode == IMC_FALLBACK)
    else $error("select low with input high not in fallback");

  a_quiet_mode: assert property ( // (R6)
    quiet |=> o_mode == IMC_SLEEP)
    else $error("quiet pins not in sleep");

  a_detect_on: assert property ( // (R9)
    !quiet |=> o_uv_det_en)
    else $error("detectors off outside quiet sleep");

  a_serial_allowed: assert property ( // (R10) (R12)
    !quiet && !i_supply.vdd_uv |=> o_serial_en)
    else $error("serial refused outside quiet sleep");

  a_so_idle_high: assert property ( // (R10)
    i_chip_select_low_n |=> o_so_oe_n)
    else $error("data output driven with chip select high");

  a_uv_map_reset: assert property ( // (R12)
    i_supply.vdd_uv |=> input_a_channel_map_q == 8'h04
      && input_b_channel_map_q == 8'h08 && out_ctrl_q == 8'h00)
    else $error("registers not reset on digital undervoltage");

  a_pin_sync_delay: assert property ( // (R16)
    $past(i_rst_n) && $past(i_rst_n, 2) |-> {lp_s, in_b_s, in_a_s}
      == $past({i_lowpower_sel, i_parallel_input_b, i_parallel_input_a}, 2))
    else $error("pin not seen two cycles after it changed");

endmodule

// [imc_host_model.sv]
// host model that drives the parallel inputs and the select pin
`timescale 1ns/1ps
module imc_host_model #(
  parameter int HOLD = 4
) (
  input wire logic i_clk,
  input wire logic i_a,
  input wire logic i_b,
  input wire logic i_sel,
  output logic o_a,
  output logic o_b,
  output logic o_sel
);
  int hold_q;
  initial begin
    o_a = 1'h0;
    o_b = 1'h0;
    o_sel = 1'h0;
    hold_q = 0;
  end
  // select held for its minimum time
  always @(posedge i_clk) begin
    o_a <= i_a;
    o_b <= i_b;
    if (hold_q > 0) begin
      hold_q <= hold_q - 1;
    end else if (i_sel != o_sel) begin
      o_sel <= i_sel;
      hold_q <= HOLD;
    end
  end
endmodule

// [imc_pkg.sv]
// types shared by the input mapping and mode control block
package imc_pkg;

  typedef enum logic [1:0] {
    IMC_SLEEP,
    IMC_IDLE,
    IMC_ACTIVE,
    IMC_FALLBACK
  } imc_mode_t;

  typedef struct packed {
    logic vs_uv;
    logic vs_op;
    logic vdd_uv;
  } imc_supply_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } imc_bus_req_t;

endpackage

// [imc_sync.sv]
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
module imc_sync #(
  parameter int W = 3
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // first stage feeds only the second stage
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= i_async[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign o_sync = sync_q;

endmodule

// [tb_top.sv]
// testbench of the input mapping and mode control block
`timescale 1ns/1ps
module tb_top;
  import imc_pkg::*;
  logic i_clk = 1'h0;
  logic i_rst_n = 1'h0;
  logic a_cmd = 1'h0;
  logic b_cmd = 1'h0;
  logic sel_cmd = 1'h0;
  logic pin_a;
  logic pin_b;
  logic pin_sel;
  logic csn_n = 1'h1;
  logic [1:0] pwm = 2'h0;
  imc_supply_t sup = 3'h2;
  imc_bus_req_t bus = '0;
  logic [7:0] rdata;
  logic [7:0] drive;
  imc_mode_t mode;
  logic ser_en;
  logic so_oe_n;
  logic uv_en;
  int errors = 0;
  int n_checks = 0;

  imc_host_model i_imc_host_model (.i_clk(i_clk), .i_a(a_cmd), .i_b(b_cmd),
    .i_sel(sel_cmd), .o_a(pin_a), .o_b(pin_b), .o_sel(pin_sel));

  imc_ctrl i_imc_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_parallel_input_a(pin_a), .i_parallel_input_b(pin_b),
    .i_lowpower_sel(pin_sel), .i_chip_select_low_n(csn_n), .i_pwm(pwm),
    .i_supply(sup), .i_bus(bus), .o_rdata(rdata), .o_chan_drive(drive),
    .o_mode(mode), .o_serial_en(ser_en), .o_so_oe_n(so_oe_n),
    .o_uv_det_en(uv_en));

  initial begin
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge i_clk);
    bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge i_clk);
    bus <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    bus <= '0;
    #1;
    chk("rdata", e, rdata);
  endtask

  // pins pass the host model and two sync flops
  task automatic settle();
    repeat (8) @(posedge i_clk);
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge i_clk);
    errors++;
    test_done();
  end

  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'h1;
    csn_n <= 1'h0;
    settle();
    chk("mode", 8'h00, {6'h00, mode});
    chk("uv_en", 8'h00, {7'h00, uv_en});
    chk("ser_en", 8'h00, {7'h00, ser_en});
    chk("so_oe_n", 8'h01, {7'h00, so_oe_n});
    $display("test quiet sleep done");
    @(posedge i_clk);
    sel_cmd <= 1'h1;
    settle();
    chk("mode", 8'h01, {6'h00, mode});
    chk("so_oe_n", 8'h00, {7'h00, so_oe_n});
    chk("uv_en", 8'h01, {7'h00, uv_en});
    chk("ser_en", 8'h01, {7'h00, ser_en});
    rd(3'h1, 8'h04);
    rd(3'h2, 8'h08);
    @(posedge i_clk);
    a_cmd <= 1'h1;
    b_cmd <= 1'h1;
    settle();
    chk("mode", 8'h02, {6'h00, mode});
    chk("drive", 8'h0C, drive);
    rd(3'h5, 8'h03);
    @(posedge i_clk);
    csn_n <= 1'h1;
    settle();
    chk("so_oe_n", 8'h01, {7'h00, so_oe_n});
    @(posedge i_clk);
    csn_n <= 1'h0;
    $display("test default map done");
    wr(3'h1, 8'h30);
    wr(3'h0, 8'h01);
    wr(3'h3, 8'h80);
    pwm <= 2'h1;
    settle();
    chk("drive", 8'hB9, drive);
    @(posedge i_clk);
    pwm <= 2'h0;
    b_cmd <= 1'h0;
    $display("test or mapping done");
    sel_cmd <= 1'h0;
    settle();
    chk("mode", 8'h03, {6'h00, mode});
    chk("drive", 8'h04, drive);
    rd(3'h5, 8'h01);
    @(posedge i_clk);
    sel_cmd <= 1'h1;
    settle();
    rd(3'h1, 8'h04);
    rd(3'h0, 8'h00);
    $display("test fallback done");
    @(posedge i_clk);
    sup <= '{vs_uv: 1'h1, vs_op: 1'h0, vdd_uv: 1'h0};
    settle();
    chk("drive", 8'h00, drive);
    @(posedge i_clk);
    sup <= '{vs_uv: 1'h0, vs_op: 1'h1, vdd_uv: 1'h0};
    settle();
    chk("drive", 8'h04, drive);
    @(posedge i_clk);
    sup <= '{vs_uv: 1'h0, vs_op: 1'h0, vdd_uv: 1'h0};
    b_cmd <= 1'h1;
    settle();
    chk("drive", 8'h04, drive);
    @(posedge i_clk);
    a_cmd <= 1'h0;
    settle();
    chk("drive", 8'h00, drive);
    $display("test analog supply done");
    @(posedge i_clk);
    sup <= '{vs_uv: 1'h1, vs_op: 1'h0, vdd_uv: 1'h1};
    wr(3'h2, 8'hFF);
    rd(3'h2, 8'h00);
    chk("ser_en", 8'h00, {7'h00, ser_en});
    @(posedge i_clk);
    sup <= '{vs_uv: 1'h0, vs_op: 1'h1, vdd_uv: 1'h0};
    rd(3'h2, 8'h08);
    chk("drive", 8'h08, drive);
    $display("test digital supply done");
    test_done();
  end
endmodule
